// File: verilog/sbc_power_up_reset_control.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_power_up_reset_control #(
  parameter int SLOW_GAP = sbc_pkg::SLOW_GAP_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire sbc_pkg::pins_type pins,
  input wire logic main_osc_tick,
  input wire logic drivers_active,
  input wire logic overtemp_raw,
  input wire logic overtemp_irq_enable,
  input wire logic overvoltage_protect_enable,
  input wire logic undervoltage_protect_enable,
  input wire logic wdt_core_expire,
  input wire logic wdt_cleared,
  input wire logic [1:0] wdt_system_limit,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  output logic system_reset_low_r,
  output logic core_supply_enable_r,
  output logic mcu_clk_enable_r,
  output logic mcu_reset_low_r,
  output logic slow_clock_select_r,
  output logic logic_tick_r,
  output logic driver_ctrl_reset_r,
  output logic drivers_auto_off_r,
  output logic interrupt_request_low_r
);
  import sbc_pkg::*;

  // ==========================================================
  // input conditioning
  pins_type ps;
  logic [PINS_W-1:0] ps_bits;
  logic slow_edge;
  logic slow_fail;
  seq_state_type state_r;
  seq_state_type state_nxt;

  pin_sync3 #(
    .WIDTH(PINS_W)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .pin_in(pins),
    .level_out(ps_bits)
  );
  assign ps = pins_type'(ps_bits);

  // main clock is stopped in sleep, so nothing to observe there
  slow_osc_monitor #(
    .GAP_CYCLES(SLOW_GAP)
  ) u_mon (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .enable(state_r != ST_SLEEP),
    .slow_level(ps.slow_oscillator),
    .slow_edge(slow_edge),
    .fail_pulse(slow_fail)
  );

  // ==========================================================
  // watchdog reset escalation
  logic [2:0] wdt_count_r;
  logic [4:0] core_hold_r;
  logic wdt_sys_req;
  logic [2:0] wdt_limit;

  // four limit settings map to one..four consecutive core resets
  assign wdt_limit = {1'b0, wdt_system_limit} + 3'h1;
  assign wdt_sys_req = wdt_core_expire && (state_r == ST_NORMAL) &&
                       (wdt_count_r == wdt_limit);

  // consecutive core reset counter, emptied by a service
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdt_count_r <= '0;
    end else if (ce) begin
      if (wdt_cleared || wdt_sys_req || state_r != ST_NORMAL) begin
        wdt_count_r <= '0;
      end else if (wdt_core_expire) begin
        wdt_count_r <= wdt_count_r + 3'h1;
      end
    end
  end

  // core reset pulse length
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_hold_r <= '0;
    end else if (ce) begin
      if (wdt_core_expire && state_r == ST_NORMAL && !wdt_sys_req) begin
        core_hold_r <= CORE_RST_CYCLES;
      end else if (core_hold_r != 5'h00) begin
        core_hold_r <= core_hold_r - 5'h01;
      end
    end
  end

  // ==========================================================
  // power-up sequencer
  logic [11:0] timer_r;
  logic timer_done;
  logic supplies_ok;

  assign supplies_ok = ps.core_buffer_supply & ps.io_regulator_supply;
  assign timer_done = (state_r == ST_SETTLE) ? (timer_r == SETTLE_LAST)
                                             : (timer_r == CHECK_LAST);

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RESET: begin
        if (ps.main_supply) begin
          state_nxt = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (timer_done) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (supplies_ok) begin
          state_nxt = ST_NORMAL;
        end else if (timer_done) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_NORMAL: begin
        if (wdt_sys_req) begin
          state_nxt = ST_RESET;
        end
      end
      ST_SLEEP: begin
        // wake is sampled on the slow clock, the only one running
        if (slow_edge && ps.lin_wake) begin
          state_nxt = ST_CHECK;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    if (!ps.main_supply) begin
      state_nxt = ST_RESET;
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_RESET;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // settle and supply check timer, restarted on each state entry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_r <= '0;
    end else if (ce) begin
      if (state_nxt != state_r) begin
        timer_r <= '0;
      end else if (!timer_done) begin
        timer_r <= timer_r + 12'h001;
      end
    end
  end

  // sequencer outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      system_reset_low_r <= 1'b0;
      core_supply_enable_r <= 1'b0;
      mcu_clk_enable_r <= 1'b0;
      mcu_reset_low_r <= 1'b0;
      slow_clock_select_r <= 1'b0;
    end else if (ce) begin
      system_reset_low_r <= (state_nxt != ST_RESET) &&
                            (state_nxt != ST_SETTLE);
      core_supply_enable_r <= (state_nxt == ST_CHECK) ||
                              (state_nxt == ST_NORMAL);
      mcu_clk_enable_r <= (state_nxt == ST_NORMAL);
      mcu_reset_low_r <= (state_nxt == ST_NORMAL) &&
                         (core_hold_r == 5'h00) &&
                         !(wdt_core_expire && state_r == ST_NORMAL);
      slow_clock_select_r <= (state_nxt == ST_SLEEP);
    end
  end

  // ==========================================================
  // logic clock enable: main oscillator / 5, slow oscillator in sleep
  logic [2:0] div_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= '0;
      logic_tick_r <= 1'b0;
    end else if (ce) begin
      logic_tick_r <= 1'b0;
      if (state_r == ST_SLEEP) begin
        div_r <= '0;
        logic_tick_r <= slow_edge;
      end else if (main_osc_tick) begin
        if (div_r == LOGIC_DIV_LAST) begin
          div_r <= '0;
          logic_tick_r <= 1'b1;
        end else begin
          div_r <= div_r + 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // over-temperature driver kill
  // sets without the clock; released only once the cooled level is seen
  always_ff @(posedge clk or posedge overtemp_raw or negedge nrst) begin
    if (overtemp_raw) begin
      driver_ctrl_reset_r <= 1'b1;
    end else if (!nrst) begin
      driver_ctrl_reset_r <= 1'b0;
    end else if (ce) begin
      driver_ctrl_reset_r <= ps.overtemp;
    end
  end

  // ==========================================================
  // reset cause status register
  status_type status_r;
  status_type status_nxt;
  status_type set_v;
  logic [7:0] clr_v;
  logic status_hit;

  assign status_hit = (reg_addr == RESET_CAUSE_STATUS_ADDR);

  // set terms; set wins over a clear in the same cycle
  always_comb begin
    set_v = '0;
    set_v.power_on_reset_flag = (state_r == ST_RESET) &&
                                !ps.main_supply;
    set_v.watchdog_core_reset_flag = wdt_core_expire &&
                                     (state_r == ST_NORMAL);
    set_v.watchdog_system_reset_flag = wdt_sys_req;
    set_v.overtemp_flag = ps.overtemp;
    set_v.undervoltage_flag = ps.undervoltage;
    set_v.overvoltage_flag = ps.overvoltage;
    set_v.pump_voltage_error_flag = ps.pump_bad && drivers_active;
    set_v.slow_clock_fail_flag = slow_fail;
    clr_v = (reg_wr && status_hit) ? reg_wdata : 8'h00;
    status_nxt = status_type'((status_r & ~clr_v) | set_v);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_r <= status_type'(RESET_CAUSE_STATUS_RST);
    end else if (ce) begin
      status_r <= status_nxt;
    end
  end

  // read port: answer one cycle after the strobe, other addresses zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_r <= '0;
    end else if (ce && reg_rd) begin
      reg_rdata_r <= status_hit ? status_r : 8'h00;
    end
  end

  // ==========================================================
  // driver auto-off and interrupt line
  // auto-off follows the sticky flags, so drivers stay off until cleared
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drivers_auto_off_r <= 1'b0;
      interrupt_request_low_r <= 1'b1;
    end else if (ce) begin
      drivers_auto_off_r <= status_nxt.pump_voltage_error_flag ||
        (status_nxt.overvoltage_flag && overvoltage_protect_enable) ||
        (status_nxt.undervoltage_flag && undervoltage_protect_enable) ||
        status_nxt.overtemp_flag;
      interrupt_request_low_r <= !(
        (status_nxt.overtemp_flag && overtemp_irq_enable) ||
        status_nxt.slow_clock_fail_flag);
    end
  end
endmodule
`default_nettype wire

// File: verilog/sbc_pkg.sv
package sbc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] RESET_CAUSE_STATUS_ADDR = 8'h00;
  localparam logic [7:0] RESET_CAUSE_STATUS_RST = 8'h01;
  localparam int POWER_ON_BIT = 0;
  localparam int WDT_CORE_BIT = 1;
  localparam int WDT_SYSTEM_BIT = 2;
  localparam int OVERTEMP_BIT = 3;
  localparam int UNDERVOLT_BIT = 4;
  localparam int OVERVOLT_BIT = 5;
  localparam int PUMP_ERR_BIT = 6;
  localparam int SLOW_FAIL_BIT = 7;

  // ==========================================================
  // clocks and timing
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MAIN_OSC_MHZ = 20;
  localparam int LOGIC_CLK_MHZ = 4;
  localparam int LOGIC_DIV = MAIN_OSC_MHZ / LOGIC_CLK_MHZ;
  localparam logic [2:0] LOGIC_DIV_LAST = 3'(LOGIC_DIV - 1);
  localparam int SLOW_OSC_KHZ = 125;
  localparam int SLOW_PERIOD_NS = 1000000 / SLOW_OSC_KHZ;
  // a stall of three slow periods counts as a stopped oscillator
  localparam int SLOW_GAP_CYCLES = 3 * SLOW_PERIOD_NS / CLK_PERIOD_NS;
  // power_up_settle_time, least time, rounded up
  localparam int SETTLE_US = 10;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  // supply_check_timeout, longest time, rounded down
  localparam int SUPPLY_CHECK_US = 20;
  localparam int SUPPLY_CHECK_CYCLES = SUPPLY_CHECK_US * CLK_MHZ;
  localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CYCLES - 1);
  localparam logic [11:0] CHECK_LAST = 12'(SUPPLY_CHECK_CYCLES - 1);
  localparam logic [4:0] CORE_RST_CYCLES = 5'h10;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_SETTLE = 3'b001,
    ST_CHECK = 3'b010,
    ST_NORMAL = 3'b011,
    ST_SLEEP = 3'b100
  } seq_state_type;

  typedef struct packed {
    logic slow_clock_fail_flag;
    logic pump_voltage_error_flag;
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic overtemp_flag;
    logic watchdog_system_reset_flag;
    logic watchdog_core_reset_flag;
    logic power_on_reset_flag;
  } status_type;

  typedef struct packed {
    logic main_supply;
    logic core_buffer_supply;
    logic io_regulator_supply;
    logic overtemp;
    logic overvoltage;
    logic undervoltage;
    logic pump_bad;
    logic lin_wake;
    logic slow_oscillator;
  } pins_type;

  localparam int PINS_W = $bits(pins_type);
endpackage

// File: verilog/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  // ==========================================================
  // three stages; a change counts once stages two and three agree
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // shift chain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else if (ce) begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // filtered level, bit by bit
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        level_out[i] <= 1'b0;
      end else if (ce && (s2_r[i] == s3_r[i])) begin
        level_out[i] <= s3_r[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/slow_osc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module slow_osc_monitor #(
  parameter int GAP_CYCLES = 4800
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic enable,
  input wire logic slow_level,
  output logic slow_edge,
  output logic fail_pulse
);
  // ==========================================================
  // counts main clock cycles between slow oscillator rises
  logic prev_r;
  logic [15:0] gap_r;
  logic stalled_r;
  localparam logic [15:0] GAP_LAST = 16'(GAP_CYCLES - 1);

  assign slow_edge = slow_level & ~prev_r;

  // gap counter; parked while disabled so wake starts clean
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 1'b0;
      gap_r <= '0;
      stalled_r <= 1'b0;
      fail_pulse <= 1'b0;
    end else if (ce) begin
      prev_r <= slow_level;
      fail_pulse <= 1'b0;
      if (!enable || slow_edge) begin
        gap_r <= '0;
        stalled_r <= 1'b0;
      end else if (gap_r == GAP_LAST) begin
        // one pulse per stall, not one per cycle
        fail_pulse <= ~stalled_r;
        stalled_r <= 1'b1;
      end else begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/sbc_reset_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checks for the power-up and reset block
module sbc_reset_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire sbc_pkg::pins_type pins,
  input wire logic overtemp_raw,
  input wire logic overtemp_irq_enable,
  input wire logic wdt_core_expire,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_r,
  input wire logic system_reset_low_r,
  input wire logic core_supply_enable_r,
  input wire logic mcu_clk_enable_r,
  input wire logic mcu_reset_low_r,
  input wire logic slow_clock_select_r,
  input wire logic logic_tick_r,
  input wire logic driver_ctrl_reset_r,
  input wire logic interrupt_request_low_r
);
  import sbc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // sequencing and reset outputs
  a_supply_drop: assert property (!pins.main_supply [*8] |=> !system_reset_low_r)
    else $error("global reset not held with supply low");
  a_sys_holds_mcu: assert property (!system_reset_low_r |-> !mcu_reset_low_r)
    else $error("core out of reset during global reset");
  a_clk_on_supply: assert property (mcu_clk_enable_r |-> core_supply_enable_r)
    else $error("core clock without core supply");
  a_release_joint: assert property ($rose(mcu_clk_enable_r) |->
    mcu_reset_low_r && system_reset_low_r)
    else $error("clock and reset release not together");
  a_sleep_no_clk: assert property (slow_clock_select_r |-> !mcu_clk_enable_r)
    else $error("core clock running in sleep");
  // a frozen cycle stretches a tick, so only a tick seen with ce high starts the gap
  a_tick_spacing: assert property (ce && logic_tick_r && !slow_clock_select_r |=>
    !logic_tick_r [*8])
    else $error("logic tick faster than divided rate");
  a_core_reset: assert property (ce && wdt_core_expire && mcu_clk_enable_r &&
    mcu_reset_low_r |-> ##[1:3] !mcu_reset_low_r)
    else $error("watchdog expiry did not reset core");

  // ==========================================================
  // protection and register port
  a_hot_holds_drv: assert property (overtemp_raw |-> driver_ctrl_reset_r)
    else $error("driver reset low while hot");
  a_ovt_irq: assert property ((overtemp_irq_enable && pins.overtemp && ce) [*8] |=>
    !interrupt_request_low_r)
    else $error("overtemp interrupt missing");
  a_unmapped_zero: assert property (ce && reg_rd &&
    reg_addr != RESET_CAUSE_STATUS_ADDR |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");

  c_sleep: cover property ($rose(slow_clock_select_r));
  c_core_rst: cover property ($fell(mcu_reset_low_r) && system_reset_low_r);
  c_irq: cover property ($fell(interrupt_request_low_r));
endmodule
`default_nettype wire

// File: tb/sbc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// oscillators: 20 MHz main ticks and a slow clock that can stall
module sbc_osc_model (
  input wire logic clk,
  input wire logic slow_run,
  input wire logic sleep_sel,
  output logic main_osc_tick,
  output logic slow_level
);
  int mcnt = 0;
  int scnt = 0;
  initial begin
    main_osc_tick = 1'b0;
    slow_level = 1'b0;
  end
  // main oscillator is stopped in sleep, so no main ticks reach the logic divider
  always @(posedge clk) begin
    mcnt <= (mcnt == 9) ? 0 : mcnt + 1;
    main_osc_tick <= #1 (mcnt == 9) && !sleep_sel;
  end
  // slow clock sped up to stay well inside the shortened gap limit
  always @(posedge clk) begin
    scnt <= (scnt == 39) ? 0 : scnt + 1;
    if (scnt == 39 && slow_run) begin
      slow_level <= #1 !slow_level;
    end
  end
endmodule
`default_nettype wire

// File: tb/sbc_power_up_reset_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_power_up_reset_control_tb;
  import sbc_pkg::*;
  logic clk, nrst, ce, ms, cb, io, ot, ov, uv, pb, lw, slow_run, slow_level, tick_main;
  logic drv_act, ot_raw, ot_en, ov_en, uv_en, wexp, wclr, rd, wr;
  logic [1:0] wlim;
  logic [7:0] addr, wdata, rdata, reg_rdata_r;
  logic system_reset_low_r, core_supply_enable_r, mcu_clk_enable_r, mcu_reset_low_r;
  logic slow_clock_select_r, logic_tick_r, driver_ctrl_reset_r, drivers_auto_off_r;
  logic interrupt_request_low_r;
  pins_type pins;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int waited, n_tick;
  assign pins = {ms, cb, io, ot, ov, uv, pb, lw, slow_level};

  sbc_power_up_reset_control #(.SLOW_GAP(200)) u_sbc_power_up_reset_control (
    .clk(clk), .nrst(nrst), .ce(ce), .pins(pins), .main_osc_tick(tick_main),
    .drivers_active(drv_act), .overtemp_raw(ot_raw), .overtemp_irq_enable(ot_en),
    .overvoltage_protect_enable(ov_en), .undervoltage_protect_enable(uv_en),
    .wdt_core_expire(wexp), .wdt_cleared(wclr), .wdt_system_limit(wlim),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata_r(reg_rdata_r),
    .system_reset_low_r(system_reset_low_r), .core_supply_enable_r(core_supply_enable_r),
    .mcu_clk_enable_r(mcu_clk_enable_r), .mcu_reset_low_r(mcu_reset_low_r),
    .slow_clock_select_r(slow_clock_select_r), .logic_tick_r(logic_tick_r),
    .driver_ctrl_reset_r(driver_ctrl_reset_r), .drivers_auto_off_r(drivers_auto_off_r),
    .interrupt_request_low_r(interrupt_request_low_r));
  sbc_osc_model u_sbc_osc_model (.clk(clk), .slow_run(slow_run),
    .sleep_sel(slow_clock_select_r), .main_osc_tick(tick_main), .slow_level(slow_level));

  // ==========================================================
  // clock, hang guard and closing report
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // the sequence needs about 8k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // access and compare tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  // strobe held for one edge, then a quiet edge before the next access
  task automatic reg_rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    tick(1);
    rdata = reg_rdata_r;
    wr = 1'b0;
    rd = 1'b0;
    tick(1);
  endtask
  task automatic chk_st(input logic [7:0] exp);
    reg_rw(1'b0, 8'h00, 8'h00);
    cmp8(rdata, exp);
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    for (waited = 0; waited < lim && s !== v; waited++) tick(1);
    cmp1(s, v);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {nrst, ce, ms, cb, io, ot, ov, uv, pb, lw, slow_run} = 11'h000;
    {drv_act, ot_raw, ot_en, ov_en, uv_en, wexp, wclr, rd, wr} = 9'h000;
    // setting zero: one core reset allowed, the next unserviced expiry escalates
    wlim = 2'b00;
    addr = 8'h00;
    wdata = 8'h00;
    tick(16);
    nrst = 1'b1;
    ce = 1'b1;
    slow_run = 1'b1;
    chk_st(8'h01);
    ms = 1'b1;
    tick(10);
    cmp1(system_reset_low_r, 1'b0);
    wait_on(core_supply_enable_r, 1'b1, 2100);
    cmp1(waited > 1900, 1'b1);
    tick(3900);
    cmp1(mcu_clk_enable_r, 1'b0);
    wait_on(slow_clock_select_r, 1'b1, 300);
    // a slow stall in sleep must leave no failure flag behind
    slow_run = 1'b0;
    tick(400);
    slow_run = 1'b1;
    {cb, io, lw} = 3'h7;
    wait_on(slow_clock_select_r, 1'b0, 400);
    lw = 1'b0;
    wait_on(mcu_clk_enable_r, 1'b1, 50);
    cmp1(mcu_reset_low_r & system_reset_low_r, 1'b1);
    chk_st(8'h01);
    reg_rw(1'b1, 8'h00, 8'h00);
    chk_st(8'h01);
    reg_rw(1'b1, 8'h00, 8'h01);
    chk_st(8'h00);
    reg_rw(1'b1, 8'h05, 8'hff);
    reg_rw(1'b0, 8'h05, 8'h00);
    cmp8(rdata, 8'h00);
    chk_st(8'h00);
    // exactly ten logic ticks fit in 500 cycles of 20 MHz ticks
    n_tick = 0;
    repeat (500) begin
      tick(1);
      n_tick += int'(logic_tick_r);
    end
    cmp8(8'(n_tick), 8'h0a);
    // driver kill must land while the clock enable is held off
    ce = 1'b0;
    ot_raw = 1'b1;
    #1 cmp1(driver_ctrl_reset_r, 1'b1);
    tick(1);
    {ce, ot, ot_en} = 3'h7;
    tick(12);
    cmp1(interrupt_request_low_r, 1'b0);
    cmp1(mcu_reset_low_r, 1'b1);
    chk_st(8'h08);
    reg_rw(1'b1, 8'h00, 8'h08);
    chk_st(8'h08);
    cmp1(driver_ctrl_reset_r, 1'b1);
    {ot, ot_raw} = 2'h0; // die reads cool before drivers come back
    tick(10);
    reg_rw(1'b1, 8'h00, 8'h08);
    chk_st(8'h00);
    cmp1(driver_ctrl_reset_r | !interrupt_request_low_r, 1'b0);
    // flag alone while protection is off, then drivers forced off
    {drv_act, ov} = 2'h3;
    tick(10);
    ov = 1'b0;
    tick(6);
    cmp1(drivers_auto_off_r, 1'b0);
    {ov_en, uv_en, uv, pb} = 4'hf;
    tick(10);
    {uv, pb} = 2'h0;
    tick(10);
    cmp1(drivers_auto_off_r, 1'b1);
    chk_st(8'h70);
    reg_rw(1'b1, 8'h00, 8'h70);
    tick(2);
    cmp1(drivers_auto_off_r, 1'b0);
    slow_run = 1'b0;
    tick(300);
    cmp1(interrupt_request_low_r, 1'b0);
    chk_st(8'h80);
    slow_run = 1'b1;
    tick(100);
    reg_rw(1'b1, 8'h00, 8'h80);
    tick(2);
    cmp1(interrupt_request_low_r, 1'b1);
    // limit of one: a service between expiries restarts the count
    pulse(wexp);
    tick(1);
    cmp1(mcu_reset_low_r, 1'b0);
    chk_st(8'h02);
    tick(30);
    pulse(wclr);
    pulse(wexp);
    tick(30);
    cmp1(system_reset_low_r & mcu_reset_low_r, 1'b1);
    pulse(wexp);
    tick(1);
    cmp1(system_reset_low_r, 1'b0);
    reg_rw(1'b0, 8'h00, 8'h00);
    cmp8(rdata & 8'h04, 8'h04);
    conclude();
  end
endmodule

bind sbc_power_up_reset_control sbc_reset_props u_sbc_reset_props (
  .clk(clk), .nrst(nrst), .ce(ce), .pins(pins), .overtemp_raw(overtemp_raw),
  .overtemp_irq_enable(overtemp_irq_enable), .wdt_core_expire(wdt_core_expire),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
  .system_reset_low_r(system_reset_low_r), .core_supply_enable_r(core_supply_enable_r),
  .mcu_clk_enable_r(mcu_clk_enable_r), .mcu_reset_low_r(mcu_reset_low_r),
  .slow_clock_select_r(slow_clock_select_r), .logic_tick_r(logic_tick_r),
  .driver_ctrl_reset_r(driver_ctrl_reset_r), .interrupt_request_low_r(interrupt_request_low_r));
`default_nettype wire
